//--- rtl/mq_pkg.sv
package mq_pkg;
    // queue geometry and write address bus fields
    localparam int         NUM_QUEUES   = 8;
    localparam int         QIDX_W       = 3;
    localparam int         DEV_MSB      = 7;
    localparam int         DEV_LSB      = 5;
    localparam int         STW_MSB      = 3;
    localparam logic [3:0] QCOUNT_MAX   = 4'h8;
    localparam logic [3:0] QCOUNT_FOUR  = 4'h4;
    localparam logic [3:0] STATUS_WORD_Q0_7 = 4'h0;
    localparam logic [3:0] STATUS_WORD_RST  = 4'hf;
    // almost-empty / almost-full offsets chosen at master reset
    localparam logic [7:0] OFFSET_SMALL = 8'h08;
    localparam logic [7:0] OFFSET_LARGE = 8'h80;
    // timing counts in clk_sys cycles
    localparam logic [4:0] SETUP_CYCLES = 5'h10;
    localparam logic [1:0] QCHG_CYCLES  = 2'h3;
    // apb register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_FULL     = 8'h04;
    localparam logic [7:0] REG_EMPTY    = 8'h08;
    localparam logic [7:0] REG_AFULL    = 8'h0c;
    localparam logic [7:0] REG_CONFIG   = 8'h10;
    localparam logic [7:0] REG_STATE    = 8'h14;
    // reset values
    localparam logic [2:0] CTRL_RST     = 3'h0;
    localparam logic [7:0] FULL_RST     = 8'h00;
    localparam logic [7:0] EMPTY_RST    = 8'hff;
    localparam logic [7:0] AFULL_RST    = 8'h00;
    // field positions of config and state words
    localparam int CFG_METHOD_LSB = 0;
    localparam int CFG_PACKET_BIT = 4;
    localparam int CFG_FALLTHRU_BIT = 5;
    localparam int CFG_OFS_LSB    = 8;
    localparam int CFG_WIDTH_LSB  = 16;
    localparam int CFG_QCNT_LSB   = 20;
    localparam int ST_DONE_BIT    = 0;
    localparam int ST_CHG_BIT     = 1;
    localparam int ST_ACTIVE_LSB  = 4;
    localparam int ST_PEND_LSB    = 8;

    typedef enum logic [2:0] {
        PM_SERIAL, PM_PAR_WRADDR, PM_PAR_RDADDR, PM_FIXED4, PM_FIXED8, PM_RESERVED
    } prog_method_t;
    typedef enum logic [1:0] {SU_IDLE, SU_LOAD, SU_DONE, SU_HOLD} setup_state_t;
endpackage

//--- rtl/mq_cfg_if.sv
interface mq_cfg_if;
    import mq_pkg::*;
    prog_method_t method;
    logic         packet_mode;
    logic         fall_through;
    logic [7:0]   offset;
    logic [3:0]   width_match;
    logic [3:0]   queue_count;
    logic         setup_done;

    modport source (output method, packet_mode, fall_through, offset, width_match,
                    queue_count, setup_done);
    modport sink   (input  method, packet_mode, fall_through, offset, width_match,
                    queue_count, setup_done);
endinterface

//--- rtl/mq_setup.sv
module mq_setup import mq_pkg::*; (
    input  logic       clk_sys,
    input  logic       nrst,
    input  logic       master_reset_n,
    input  logic       default_mode_select,
    input  logic       offset_value_select,
    input  logic       queue_method_sel_hi,
    input  logic       queue_method_sel_lo,
    input  logic [3:0] width_match_select,
    input  logic       packet_mode_pin,
    input  logic       fall_through_pin,
    input  logic [7:0] write_queue_addr,
    input  logic [7:0] read_queue_addr,
    input  logic       program_enable_in_n,
    output logic       program_done_out_n,
    mq_cfg_if.source   cfg
);
    setup_state_t state_q;
    logic [4:0]   cnt_q;
    logic         mrst_prev_q;
    logic         mrst_rise;
    prog_method_t method_in;

    // pin combination to programming method
    function automatic prog_method_t decode(input logic dflt, input logic hi, input logic lo);
        if (!dflt) return (hi & lo) ? PM_SERIAL : PM_RESERVED;
        if (!hi) return lo ? PM_PAR_RDADDR : PM_PAR_WRADDR; // [RL8] [RL24]
        return lo ? PM_FIXED8 : PM_FIXED4; // [RL24]
    endfunction

    assign method_in = decode(default_mode_select, queue_method_sel_hi, queue_method_sel_lo);
    assign mrst_rise = master_reset_n & ~mrst_prev_q;
    assign cfg.setup_done = (state_q == SU_DONE);

    always_ff @(posedge clk_sys) begin
        if (!nrst) mrst_prev_q <= 1'b1;
        else mrst_prev_q <= master_reset_n;
    end

    // first stage: everything latched on the master reset rising edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg.method       <= PM_RESERVED;
            cfg.packet_mode  <= 1'b0;
            cfg.fall_through <= 1'b0;
            cfg.width_match  <= 4'h0;
            cfg.offset       <= OFFSET_SMALL;
        end else if (mrst_rise) begin
            cfg.method       <= method_in; // [RL11]
            cfg.packet_mode  <= packet_mode_pin; // [RL12]
            cfg.fall_through <= fall_through_pin; // [RL12]
            cfg.width_match  <= width_match_select; // [RL10]
            cfg.offset       <= offset_value_select ? OFFSET_LARGE : OFFSET_SMALL; // [RL3]
        end
    end

    // second stage: load setup registers on write clock edges after reset
    always_ff @(posedge clk_sys) begin
        if (!nrst || !master_reset_n) begin
            state_q <= SU_IDLE;
            cnt_q   <= 5'h0;
        end else begin
            case (state_q)
                SU_IDLE: begin
                    cnt_q <= 5'h0;
                    // serial loading lives elsewhere; default mode never waits on it
                    if (mrst_rise) begin
                        state_q <= (method_in == PM_SERIAL || method_in == PM_RESERVED)
                                   ? SU_HOLD : SU_LOAD; // [RL1] [RL11]
                    end
                end
                SU_LOAD: begin
                    cnt_q <= cnt_q + 5'h1; // [RL4]
                    if (cnt_q == SETUP_CYCLES - 5'h1) state_q <= SU_DONE;
                end
                SU_DONE: state_q <= SU_DONE;
                SU_HOLD: state_q <= SU_HOLD;
                default: state_q <= SU_IDLE;
            endcase
        end
    end

    // queue count taken in the first load cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cfg.queue_count <= QCOUNT_MAX;
        end else if (state_q == SU_LOAD && cnt_q == 5'h0) begin
            case (cfg.method)
                PM_PAR_WRADDR: cfg.queue_count <= {1'b0, write_queue_addr[2:0]} + 4'h1; // [RL9]
                PM_PAR_RDADDR: cfg.queue_count <= {1'b0, read_queue_addr[2:0]} + 4'h1; // [RL9]
                PM_FIXED4:     cfg.queue_count <= QCOUNT_FOUR; // [RL24]
                default:       cfg.queue_count <= QCOUNT_MAX; // [RL2]
            endcase
        end
    end

    // done stays high while loading, then follows the chain enable
    always_ff @(posedge clk_sys) begin
        if (!nrst) program_done_out_n <= 1'b1;
        else program_done_out_n <= !(state_q == SU_DONE && !program_enable_in_n); // [RL5] [RL23] [RL7]
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_load_done_hi: assert property ((state_q == SU_LOAD) |=> program_done_out_n) // [RL5]
        else $error("done low while setup still loading");
    a_load_length: assert property ($rose(state_q == SU_LOAD) |-> // [RL4]
        (state_q == SU_LOAD) [*8])
        else $error("setup load ended too early");
    a_done_follows: assert property ((state_q == SU_DONE) |=> // [RL23]
        (program_done_out_n == $past(program_enable_in_n)))
        else $error("done output not following enable");
    a_offset_latch: assert property (mrst_rise |=> // [RL3]
        cfg.offset == ($past(offset_value_select) ? OFFSET_LARGE : OFFSET_SMALL))
        else $error("offset not latched from select pin");
    a_default_no_serial: assert property (mrst_rise && default_mode_select // [RL1]
        |=> state_q != SU_HOLD)
        else $error("default mode waiting for serial load");
    a_parallel_entry: assert property (mrst_rise && default_mode_select // [RL8]
        && !queue_method_sel_hi |=> cfg.method inside {PM_PAR_WRADDR, PM_PAR_RDADDR})
        else $error("parallel programming not entered");
endmodule

//--- rtl/mq_status_sel.sv
module mq_status_sel import mq_pkg::*; (
    input  logic       clk_sys,
    input  logic       nrst,
    input  logic       write_addr_enable,
    input  logic       status_strobe_write,
    input  logic [7:0] write_queue_addr,
    input  logic [2:0] device_identity_inputs,
    input  logic [7:0] queue_almost_full,
    input  logic       setup_done,
    output logic [7:0] almost_full_flag_n
);
    logic [3:0] word_q;
    logic       hit;

    // status word pick needs address enable low and our own device code
    assign hit = !write_addr_enable && status_strobe_write
              && write_queue_addr[DEV_MSB:DEV_LSB] == device_identity_inputs; // [RL21]

    always_ff @(posedge clk_sys) begin
        if (!nrst) word_q <= STATUS_WORD_RST;
        else if (hit) word_q <= write_queue_addr[STW_MSB:0];
    end

    // unmapped words leave the bus released high
    always_ff @(posedge clk_sys) begin
        if (!nrst) almost_full_flag_n <= 8'hff;
        else if (setup_done && word_q == STATUS_WORD_Q0_7) almost_full_flag_n <= ~queue_almost_full;
        else almost_full_flag_n <= 8'hff;
    end

    a_status_map: assert property (@(posedge clk_sys) disable iff (!nrst) // [RL21]
        (setup_done && word_q == STATUS_WORD_Q0_7) |=>
        almost_full_flag_n == ~$past(queue_almost_full))
        else $error("almost-full bus not mapped to queues 0 to 7");
endmodule

//--- rtl/mq_flow_ctrl.sv
// Functional notes
// [RL1] default mode pin high: built-in setup, no serial
// [RL2] default mode: eight queues, memory split equally
// [RL3] offsets 8 or 128 from offset select pin
// [RL4] controller clocks until done output falls
// [RL5] done output falls high-to-low when setup completes
// [RL6] controller holds enable low during default setup
// [RL7] cascade: done feeds next enable, master ends
// [RL8] default high, upper select low: parallel programming
// [RL9] parallel: queue count from address bus after reset
// [RL10] width matching fixed at master reset only
// [RL11] two stages: latch modes, then load values
// [RL12] packet and fall-through pins decode four modes; here packet mode is only latched and the flags follow fall-through alone
// [RL13] standard: read flag low when queue empty
// [RL14] standard: write flag low when queue full
// [RL15] fall-through: read flag high when nothing readable
// [RL16] fall-through: write flag low when write possible
// [RL17] address enable high samples queue, ignoring write enable
// [RL18] queue change takes four cycles, then sticks
// [RL19] write every edge with enable low, none otherwise
// [RL20] flag tracks new queue; full queue blocks writes
// [RL21] address bus fields: device, queue, status word
// [RL22] selection with foreign device code is ignored
// [RL23] after setup, done output follows enable input
// [RL24] lower select picks bus; upper fixes four/eight
module mq_flow_ctrl import mq_pkg::*; (
    input  logic        clk_sys,
    input  logic        nrst,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        master_reset_n,
    input  logic        default_mode_select,
    input  logic        offset_value_select,
    input  logic        queue_method_sel_hi,
    input  logic        queue_method_sel_lo,
    input  logic [3:0]  width_match_select,
    input  logic        packet_mode_pin,
    input  logic        fall_through_pin,
    input  logic        program_enable_in_n,
    output logic        program_done_out_n,
    input  logic [7:0]  write_queue_addr,
    input  logic [7:0]  read_queue_addr,
    input  logic        write_addr_enable,
    input  logic        write_enable_n,
    input  logic        status_strobe_write,
    input  logic [2:0]  device_identity_inputs,
    output logic        full_flag_n,
    output logic        empty_flag_n,
    output logic [7:0]  almost_full_flag_n,
    output logic        write_strobe,
    output logic [2:0]  write_queue_index
);
    mq_cfg_if cfg ();

    logic [QIDX_W-1:0] active_q;
    logic [QIDX_W-1:0] pend_q;
    logic [1:0]        chg_cnt_q;
    logic [QIDX_W-1:0] rd_queue_q;
    logic [7:0]        full_q;
    logic [7:0]        empty_q;
    logic [7:0]        afull_q;
    logic              sel_match;
    logic [QIDX_W-1:0] wq;
    logic [QIDX_W-1:0] fq;
    logic              wq_full;
    logic              fq_full;
    logic              rq_empty;
    logic              accept;
    logic              apb_setup;
    logic              apb_wr;
    logic [31:0]       rd_data;
    logic              rd_hit;
    logic [31:0]       cfg_word;
    logic [31:0]       state_word;

    // mode latch, setup sequencing and the chained done output
    mq_setup u_setup (
        .clk_sys             (clk_sys),
        .nrst                (nrst),
        .master_reset_n      (master_reset_n),
        .default_mode_select (default_mode_select),
        .offset_value_select (offset_value_select),
        .queue_method_sel_hi (queue_method_sel_hi),
        .queue_method_sel_lo (queue_method_sel_lo),
        .width_match_select  (width_match_select),
        .packet_mode_pin     (packet_mode_pin),
        .fall_through_pin    (fall_through_pin),
        .write_queue_addr    (write_queue_addr),
        .read_queue_addr     (read_queue_addr),
        .program_enable_in_n (program_enable_in_n),
        .program_done_out_n  (program_done_out_n),
        .cfg                 (cfg.source)
    );

    // almost-full status bus, polled by status word
    mq_status_sel u_status (
        .clk_sys                (clk_sys),
        .nrst                   (nrst),
        .write_addr_enable      (write_addr_enable),
        .status_strobe_write    (status_strobe_write),
        .write_queue_addr       (write_queue_addr),
        .device_identity_inputs (device_identity_inputs),
        .queue_almost_full      (afull_q),
        .setup_done             (cfg.setup_done),
        .almost_full_flag_n     (almost_full_flag_n)
    );

    // queue selection: device code must match, write enable plays no part
    assign sel_match = write_addr_enable && cfg.setup_done
                    && write_queue_addr[DEV_MSB:DEV_LSB] == device_identity_inputs; // [RL17] [RL22]

    // write target switches on the fourth edge of a change
    assign wq = (chg_cnt_q == 2'h1) ? pend_q : active_q; // [RL18]
    // flag shows the new queue one edge before writes reach it
    assign fq = (chg_cnt_q == 2'h1 || chg_cnt_q == 2'h2) ? pend_q : active_q; // [RL20]
    assign wq_full  = full_q[wq];
    assign fq_full  = full_q[fq];
    assign rq_empty = empty_q[rd_queue_q] | ~cfg.setup_done;
    assign accept   = !write_enable_n && cfg.setup_done && !wq_full; // [RL19] [RL20]

    // selection pipeline; a fresh selection restarts the change
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            active_q  <= '0;
            pend_q    <= '0;
            chg_cnt_q <= 2'h0;
        end else if (sel_match) begin
            pend_q    <= write_queue_addr[QIDX_W-1:0]; // [RL17] [RL21]
            chg_cnt_q <= QCHG_CYCLES; // [RL18]
        end else if (chg_cnt_q != 2'h0) begin
            chg_cnt_q <= chg_cnt_q - 2'h1;
            if (chg_cnt_q == 2'h1) active_q <= pend_q; // [RL18]
        end
    end

    // write strobe toward the queue memory, also during a change
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            write_strobe      <= 1'b0;
            write_queue_index <= 3'h0;
        end else begin
            write_strobe      <= accept; // [RL19]
            write_queue_index <= wq;
        end
    end

    // shared flags; both held inactive high until setup is done
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            full_flag_n  <= 1'b1;
            empty_flag_n <= 1'b1;
        end else if (!cfg.setup_done) begin
            full_flag_n  <= 1'b1;
            empty_flag_n <= 1'b1;
        end else if (cfg.fall_through) begin
            full_flag_n  <= fq_full; // [RL16]
            empty_flag_n <= rq_empty; // [RL15]
        end else begin
            full_flag_n  <= ~fq_full; // [RL14]
            empty_flag_n <= ~rq_empty; // [RL13]
        end
    end

    // apb: data and ready are prepared in the setup phase, so no wait states
    assign apb_setup = psel && !penable;
    assign apb_wr    = psel && penable && pwrite && pready;

    always_comb begin
        cfg_word = 32'h0;
        cfg_word[CFG_METHOD_LSB +: 3] = cfg.method;
        cfg_word[CFG_PACKET_BIT]      = cfg.packet_mode;
        cfg_word[CFG_FALLTHRU_BIT]    = cfg.fall_through;
        cfg_word[CFG_OFS_LSB +: 8]    = cfg.offset;
        cfg_word[CFG_WIDTH_LSB +: 4]  = cfg.width_match;
        cfg_word[CFG_QCNT_LSB +: 4]   = cfg.queue_count;
    end

    always_comb begin
        state_word = 32'h0;
        state_word[ST_DONE_BIT]            = cfg.setup_done;
        state_word[ST_CHG_BIT]             = (chg_cnt_q != 2'h0);
        state_word[ST_ACTIVE_LSB +: QIDX_W] = active_q;
        state_word[ST_PEND_LSB +: QIDX_W]   = pend_q;
    end

    // read mux; unmapped offsets read zero and flag an error
    always_comb begin
        rd_data = 32'h0;
        rd_hit  = 1'b1;
        case (paddr)
            REG_CTRL:   rd_data = {29'h0, rd_queue_q};
            REG_FULL:   rd_data = {24'h0, full_q};
            REG_EMPTY:  rd_data = {24'h0, empty_q};
            REG_AFULL:  rd_data = {24'h0, afull_q};
            REG_CONFIG: rd_data = cfg_word;
            REG_STATE:  rd_data = state_word;
            default:    rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !rd_hit;
            prdata  <= (apb_setup && !pwrite) ? rd_data : 32'h0;
        end
    end

    // queue fill state stands in for the memory, which lives outside this block
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rd_queue_q <= CTRL_RST;
            full_q     <= FULL_RST;
            empty_q    <= EMPTY_RST;
            afull_q    <= AFULL_RST;
        end else if (apb_wr) begin
            case (paddr)
                REG_CTRL:  rd_queue_q <= pwdata[QIDX_W-1:0];
                REG_FULL:  full_q     <= pwdata[7:0];
                REG_EMPTY: empty_q    <= pwdata[7:0];
                REG_AFULL: afull_q    <= pwdata[7:0];
                default:   ;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_select;
        sel_match;
    endsequence
    sequence s_quiet3;
        !sel_match [*3];
    endsequence

    a_queue_switch: assert property (s_select ##1 s_quiet3 |=> // [RL18]
        active_q == $past(write_queue_addr[QIDX_W-1:0], 4))
        else $error("write queue not switched after four cycles");
    a_queue_hold: assert property ((!sel_match && chg_cnt_q == 2'h0) |=> // [RL18]
        $stable(active_q))
        else $error("write queue changed without selection");
    a_foreign_id: assert property ((write_addr_enable && // [RL22]
        write_queue_addr[DEV_MSB:DEV_LSB] != device_identity_inputs && chg_cnt_q == 2'h0)
        |=> chg_cnt_q == 2'h0)
        else $error("foreign device code started a change");
    a_write_taken: assert property ((!write_enable_n && cfg.setup_done && !wq_full) // [RL19]
        |=> write_strobe && write_queue_index == $past(wq))
        else $error("enabled write not taken");
    a_write_idle: assert property (write_enable_n |=> !write_strobe) // [RL19]
        else $error("write taken with enable high");
    a_full_block: assert property (wq_full |=> !write_strobe) // [RL20]
        else $error("write into full queue");
    a_full_std: assert property ((cfg.setup_done && !cfg.fall_through) // [RL14]
        |=> full_flag_n == !$past(fq_full))
        else $error("standard full flag wrong");
    a_ready_fallthru: assert property ((cfg.setup_done && cfg.fall_through) // [RL16]
        |=> full_flag_n == $past(fq_full))
        else $error("input ready flag wrong");
    a_empty_std: assert property ((cfg.setup_done && !cfg.fall_through) // [RL13]
        |=> empty_flag_n == !$past(rq_empty))
        else $error("standard empty flag wrong");
    a_ready_out: assert property ((cfg.setup_done && cfg.fall_through) // [RL15]
        |=> empty_flag_n == $past(rq_empty))
        else $error("output ready flag wrong");
    a_apb_ready: assert property (apb_setup |=> pready ##1 !pready)
        else $error("apb access not one cycle");
endmodule

//--- sim/mq_host_model.sv
module mq_host_model (
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic       hold_off,
    input  wire logic [5:0] mode,
    output logic            master_reset_n,
    output logic [5:0]      pins,
    output logic            program_enable_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] rst_cnt_q = 2'h0;
    logic [5:0] pins_q    = 6'h00;
    // mode pins change with the pulse and hold through the rise
    always_ff @(posedge clk_sys) begin
        if (go) begin
            rst_cnt_q <= 2'h3;
            pins_q    <= mode;
        end else if (rst_cnt_q != 2'h0) begin
            rst_cnt_q <= rst_cnt_q - 2'h1;
        end
    end
    assign master_reset_n = (rst_cnt_q == 2'h0);
    assign pins           = pins_q;
    // first device of a chain: enable low unless the bench lets go
    assign program_enable_in_n = hold_off;
endmodule

//--- sim/tb_top.sv
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_top import mq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, write_queue_addr = 8'h00, almost_full_flag_n;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, slv, program_done_out_n, master_reset_n, program_enable_in_n;
    logic        go = 1'b0, hold_off = 1'b0, write_addr_enable = 1'b0, write_enable_n = 1'b1;
    logic        status_strobe_write = 1'b0, full_flag_n, empty_flag_n, write_strobe;
    logic [5:0]  mode = 6'h00, pins;
    logic [3:0]  width_match_select = 4'h3;
    logic [2:0]  write_queue_index;
    int          err_count = 0, n_tests = 0;
    localparam logic [2:0] MY_ID = 3'h5;
    // free-running write clock keeps the setup load moving
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    mq_flow_ctrl u_dut (
        .clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .master_reset_n, .default_mode_select(pins[5]), .offset_value_select(pins[4]),
        .queue_method_sel_hi(pins[3]), .queue_method_sel_lo(pins[2]), .width_match_select,
        .packet_mode_pin(pins[1]), .fall_through_pin(pins[0]), .program_enable_in_n,
        .program_done_out_n, .write_queue_addr, .read_queue_addr(8'h00), .write_addr_enable,
        .write_enable_n, .status_strobe_write, .device_identity_inputs(MY_ID), .full_flag_n,
        .empty_flag_n, .almost_full_flag_n, .write_strobe, .write_queue_index);
    mq_host_model u_host (.clk_sys, .go, .hold_off, .mode, .master_reset_n, .pins,
        .program_enable_in_n);
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one apb transfer; waits for pready, never a fixed count
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask
    // pulse master reset with the given pins, then wait for done to fall
    task automatic configure(input logic [5:0] m);
        int n;
        n = 0;
        @(posedge clk_sys);
        mode <= m;
        go   <= 1'b1;
        @(posedge clk_sys);
        go   <= 1'b0;
        repeat (6) @(posedge clk_sys);
        while (program_done_out_n !== 1'b0 && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(program_done_out_n, 1'b0)
        if (n >= 60) report_and_stop();
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        `CHK(program_done_out_n, 1'b1)
        configure(6'b111110);
        width_match_select <= 4'h9;
        apb(1'b0, REG_CONFIG, 32'h0);
        `CHK(rd, {8'h00, QCOUNT_MAX, 4'h3, OFFSET_LARGE, 5'h02, PM_FIXED8})
        `CHK(empty_flag_n, 1'b0)
        `CHK(full_flag_n, 1'b1)
        hold_off <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(program_done_out_n, 1'b1)
        hold_off <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK(program_done_out_n, 1'b0)
        apb(1'b1, REG_FULL, 32'h04);
        apb(1'b1, 8'h40, 32'h0);
        `CHK(slv, 1'b1)
        // own code first, then a foreign one that must not restart the change
        write_enable_n    <= 1'b0;
        write_addr_enable <= 1'b1;
        write_queue_addr  <= {MY_ID, 5'h02};
        @(posedge clk_sys);
        write_queue_addr  <= {3'h1, 5'h01};
        @(posedge clk_sys);
        write_addr_enable <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            #1;
            `CHK(write_strobe, 1'(i < 2))
            if (i < 2) `CHK(write_queue_index, 3'h0)
            @(posedge clk_sys);
        end
        `CHK(full_flag_n, 1'b0)
        apb(1'b1, REG_FULL, 32'h00);
        #1;
        `CHK(write_queue_index, 3'h2)
        write_enable_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(write_strobe, 1'b0)
        apb(1'b1, REG_AFULL, 32'h05);
        write_queue_addr    <= {MY_ID, 5'h00};
        status_strobe_write <= 1'b1;
        @(posedge clk_sys);
        status_strobe_write <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK(almost_full_flag_n, 8'hfa)
        // parallel setup from the write bus, fall-through flags
        write_queue_addr <= {MY_ID, 5'h03};
        configure(6'b100001);
        apb(1'b0, REG_CONFIG, 32'h0);
        `CHK(rd, {8'h00, QCOUNT_FOUR, 4'h9, OFFSET_SMALL, 5'h04, PM_PAR_WRADDR})
        apb(1'b1, REG_EMPTY, 32'hff);
        apb(1'b1, REG_FULL, 32'h00);
        repeat (2) @(posedge clk_sys);
        `CHK(full_flag_n, 1'b0)
        `CHK(empty_flag_n, 1'b1)
        apb(1'b1, REG_FULL, 32'hff);
        repeat (2) @(posedge clk_sys);
        `CHK(full_flag_n, 1'b1)
        // queue count from the read bus, then the fixed four-queue code
        configure(6'b100100);
        apb(1'b0, REG_CONFIG, 32'h0);
        `CHK(rd, {8'h00, 4'h1, 4'h9, OFFSET_SMALL, 5'h00, PM_PAR_RDADDR})
        configure(6'b111000);
        apb(1'b0, REG_CONFIG, 32'h0);
        `CHK(rd, {8'h00, QCOUNT_FOUR, 4'h9, OFFSET_LARGE, 5'h00, PM_FIXED4})
        report_and_stop();
    end
endmodule
